//--- hdl/break_match_if.sv
// Purpose: Carries breakpoint settings and current accesses to the matcher
// Assumes: Single clock, no timing of its own
// Notes:   Hits are raw, not gated by enables or valids
`timescale 1ns/100ps
interface break_match_if;
	import debug_break_pkg::*;
	word_t       addr [4];
	break_kind_e kind [4];
	break_len_e  len  [4];
	word_t       fetch_addr;
	word_t       data_addr;
	break_len_e  data_size;
	logic        data_write;
	logic [3:0]  exec_hit;
	logic [3:0]  data_hit;
	modport cfg   (output addr, kind, len, fetch_addr, data_addr, data_size, data_write,
	               input exec_hit, data_hit);
	modport match (input addr, kind, len, fetch_addr, data_addr, data_size, data_write,
	               output exec_hit, data_hit);
endinterface

//--- hdl/break_matcher.sv
// Purpose: Address, type and length compare for all breakpoints
// Assumes: Addresses do not wrap past the top of the linear space
// Notes:   Purely combinational
`timescale 1ns/100ps
module break_matcher
	import debug_break_pkg::*;
(
	// Settings and accesses
	break_match_if.match bif
);
	`include "debug_break_params.svh"

	// Unused encodings give zero bytes, which still match when the other range strictly straddles their address
	function automatic logic [2:0] len_bytes(input break_len_e l);
		unique case (l)
			LEN_ONE:    return 3'h1;
			LEN_TWO:    return 3'h2;
			LEN_FOUR:   return 3'h4;
			LEN_UNUSED: return 3'h0;
		endcase
	endfunction

	function automatic logic overlap(input word_t a, input logic [2:0] asz, input word_t b, input logic [2:0] bsz);
		logic [32:0] a_end;
		logic [32:0] b_end;
		a_end = {1'b0, a} + {30'h0, asz};
		b_end = {1'b0, b} + {30'h0, bsz};
		return ({1'b0, a} < b_end) && ({1'b0, b} < a_end);
	endfunction

	genvar i;
	generate
		for (i = 0; i < `BP_COUNT; i++) begin : g_bp
			wire [2:0] region = len_bytes(bif.len[i]);
			wire       kind_ok = (bif.kind[i] == KIND_RW) || ((bif.kind[i] == KIND_WRITE) && bif.data_write);
			// Instruction start must fall inside the region
			assign bif.exec_hit[i] = (bif.kind[i] == KIND_EXEC) &&
			                         overlap(bif.fetch_addr, 3'h1, bif.addr[i], region);
			// Any overlapping byte of the access counts
			assign bif.data_hit[i] = kind_ok &&
			                         overlap(bif.data_addr, len_bytes(bif.data_size), bif.addr[i], region);
		end
	endgenerate
endmodule

//--- hdl/debug_break_params.svh
// Purpose: Offsets, field positions and reset values of the breakpoint unit
// Assumes: Included by bare name after the package
// Notes:   Selector codes follow the register numbers of the move instruction
`ifndef DEBUG_BREAK_PARAMS_SVH
`define DEBUG_BREAK_PARAMS_SVH

`define BP_COUNT          4
`define SEL_ADDR_LAST     3'h3
`define SEL_STATUS        3'h6
`define SEL_CONTROL       3'h7
`define TRAP_STEP_BIT     8
`define CTRL_LOCK_BIT     13
`define CTRL_KIND_LSB     16
`define CTRL_LEN_LSB      18
`define CTRL_FIELD_STRIDE 4
`define CTRL_LOCAL_MASK   32'h0000_0055
`define CTRL_WR_MASK      32'hFFFF_23FF
`define CTRL_RESET        32'h0000_0400
`define STATUS_STEP_BIT   14
`define STATUS_TASK_BIT   15
`define STATUS_FIXED      32'h0000_0FF0

`endif

//--- hdl/debug_break_pkg.sv
// Purpose: Types shared by the breakpoint unit
// Assumes: Nothing
// Notes:   Field codes are the hardware encodings
package debug_break_pkg;
	typedef logic [31:0] word_t;
	typedef enum logic [1:0] {
		KIND_EXEC    = 2'h0,
		KIND_WRITE   = 2'h1,
		KIND_UNUSED  = 2'h2,
		KIND_RW      = 2'h3
	} break_kind_e;
	typedef enum logic [1:0] {
		LEN_ONE      = 2'h0,
		LEN_TWO      = 2'h1,
		LEN_UNUSED   = 2'h2,
		LEN_FOUR     = 2'h3
	} break_len_e;
endpackage

//--- hdl/debug_breakpoint_unit.sv
// Purpose: Hardware breakpoints, single step and task traps of the core
// Assumes: All inputs come from core logic on ref_clk
// Notes:   debug_exc and exec_break are combinational so the core can stop in time
`timescale 1ns/100ps

// Notes on behaviour
// - The status register records the hits, single step and task switch causes present when the debug exception is taken.
// - Status flags are never cleared by hardware, only by a software write.
// - The one-byte breakpoint trap instruction raises a debug exception regardless of the address registers.
// - With the trap step flag (bit 8 of the processor flags) set, each completed instruction raises a debug exception.
// - Access type 00 is execute, 01 data write, 11 data read or write, and 10 is unused.
// - Length 00 is one byte, 01 two bytes, 11 four bytes, and 10 is unused.
// - A global enable makes its breakpoint active for all tasks and survives task switches.
// - A local enable is for the current task only and is cleared on every task switch.
// - The debug access lock blocks debug register access and is cleared on any debug exception.
// - Each hit flag is set when its breakpoint matches at exception time, even when not enabled.
// - The task switch flag is set when a switch enters a task whose trap bit is set.
// - The single step flag is set when the exception came from single step mode.
// - An execute breakpoint fires before the matching instruction executes.
// - Four address registers each pair with their own enables, type and length fields.
// - Debug registers are reachable only by moves at privilege level 0, real mode counting as 0.
module debug_breakpoint_unit
	import debug_break_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       srst,
	// Move instruction register port
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [2:0] reg_sel,
	input  wire word_t      reg_wdata,
	input  wire logic [1:0] cur_priv,
	input  wire logic       real_mode,
	output word_t           reg_rdata,
	output logic            priv_fault,
	// Instruction stream
	input  wire logic       fetch_valid,
	input  wire word_t      fetch_addr,
	input  wire logic       instr_done,
	input  wire word_t      processor_flags_reg,
	input  wire logic       breakpoint_trap_instr,
	// Data accesses
	input  wire logic       data_valid,
	input  wire logic       data_write,
	input  wire word_t      data_addr,
	input  wire logic [1:0] data_size,
	// Task switches
	input  wire logic       task_switch,
	input  wire logic       task_trap_bit,
	// Exception request
	output logic            debug_exc,
	output logic            exec_break
);
	`include "debug_break_params.svh"

	// Selector decode shared by the write and read paths
	function automatic logic is_addr_sel(input logic [2:0] s);
		return (s <= `SEL_ADDR_LAST);
	endfunction

	word_t      breakpoint_address_reg [4];
	word_t      debug_control_reg;
	logic [5:0] status_flags;
	word_t      next_control;
	logic [5:0] next_flags;

	break_match_if bif ();
	break_matcher u_matcher (.bif(bif));

	// Field decode
	wire        priv_ok     = (cur_priv == 2'h0) || real_mode;
	wire        access      = reg_wr || reg_rd;
	wire        lock        = debug_control_reg[`CTRL_LOCK_BIT];
	wire        lock_trip   = access && priv_ok && lock;
	wire        wr_ok       = reg_wr && priv_ok && !lock;
	wire        rd_ok       = reg_rd && priv_ok && !lock;
	wire        addr_wr     = wr_ok && is_addr_sel(reg_sel);
	wire        status_wr   = wr_ok && (reg_sel == `SEL_STATUS);
	wire        control_wr  = wr_ok && (reg_sel == `SEL_CONTROL);
	wire [3:0]  bp_enable;
	wire [3:0]  global_bits = {debug_control_reg[7], debug_control_reg[5], debug_control_reg[3], debug_control_reg[1]};
	wire [3:0]  exec_seen   = bif.exec_hit & {4{fetch_valid}};
	wire [3:0]  data_seen   = bif.data_hit & {4{data_valid}};
	wire        exec_trip   = |(exec_seen & bp_enable);
	wire        data_trip   = |(data_seen & bp_enable);
	wire        step_trip   = instr_done && processor_flags_reg[`TRAP_STEP_BIT];
	wire        task_trip   = task_switch && task_trap_bit;
	wire        take        = exec_trip || data_trip || step_trip || breakpoint_trap_instr || task_trip || lock_trip;
	// Flag order: B0..B3, step, task
	wire [5:0]  flag_set    = take ? {task_trip, step_trip, exec_seen | data_seen} :
	                          6'h00;
	wire [5:0]  flag_wdata  = {reg_wdata[`STATUS_TASK_BIT], reg_wdata[`STATUS_STEP_BIT], reg_wdata[3:0]};
	wire word_t status_word = `STATUS_FIXED | {16'h0, status_flags[5], status_flags[4], 10'h0, status_flags[3:0]};

	genvar i;
	generate
		for (i = 0; i < `BP_COUNT; i++) begin : g_cfg
			assign bp_enable[i] = debug_control_reg[2*i] || debug_control_reg[2*i+1];
			assign bif.addr[i]  = breakpoint_address_reg[i];
			assign bif.kind[i]  = break_kind_e'(debug_control_reg[`CTRL_KIND_LSB+`CTRL_FIELD_STRIDE*i +: 2]);
			assign bif.len[i]   = break_len_e'(debug_control_reg[`CTRL_LEN_LSB+`CTRL_FIELD_STRIDE*i +: 2]);
		end
	endgenerate

	assign bif.fetch_addr = fetch_addr;
	assign bif.data_addr  = data_addr;
	assign bif.data_size  = break_len_e'(data_size);
	assign bif.data_write = data_write;

	// Outputs the core must see in the same cycle
	assign debug_exc  = take;
	assign exec_break = exec_trip;
	assign priv_fault = access && !priv_ok;

	// Hardware updates override the software write so no event is lost
	always_comb begin
		next_control = control_wr ? ((reg_wdata & `CTRL_WR_MASK) | `CTRL_RESET) : debug_control_reg;
		if (task_switch)
			next_control = next_control & ~`CTRL_LOCAL_MASK;
		if (take)
			next_control[`CTRL_LOCK_BIT] = 1'b0;
		next_flags = (status_wr ? flag_wdata : status_flags) | flag_set;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			debug_control_reg <= `CTRL_RESET;
			status_flags      <= 6'h00;
		end else begin
			debug_control_reg <= next_control;
			status_flags      <= next_flags;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			breakpoint_address_reg <= '{default: 32'h0000_0000};
		else if (addr_wr)
			breakpoint_address_reg[reg_sel[1:0]] <= reg_wdata;
	end

	// Read data is registered; a refused read returns zero
	always_ff @(posedge ref_clk) begin
		if (srst || !rd_ok)
			reg_rdata <= 32'h0000_0000;
		else if (is_addr_sel(reg_sel))
			reg_rdata <= breakpoint_address_reg[reg_sel[1:0]];
		else if (reg_sel == `SEL_STATUS)
			reg_rdata <= status_word;
		else if (reg_sel == `SEL_CONTROL)
			reg_rdata <= debug_control_reg;
		else
			reg_rdata <= 32'h0000_0000;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_step_take;
		instr_done && processor_flags_reg[`TRAP_STEP_BIT];
	endsequence
	sequence s_step_logged;
		status_flags[4] ##1 status_flags[4] || $past(status_wr);
	endsequence
	sequence s_task_trap;
		task_switch && task_trap_bit;
	endsequence
	sequence s_exec_armed0;
		fetch_valid && debug_control_reg[0] && debug_control_reg[19:16] == 4'h0 &&
		fetch_addr == breakpoint_address_reg[0];
	endsequence
	sequence s_locked_read;
		reg_rd && priv_ok && lock;
	endsequence
	sequence s_quiet;
		!fetch_valid && !data_valid && !instr_done && !breakpoint_trap_instr && !task_switch && !access;
	endsequence

	AST_HIT_CAPTURE: assert property (fetch_valid && bif.exec_hit[0] && take |=> status_flags[0])
		else $error("hit flag 0 not captured");
	AST_STICKY: assert property (|($past(status_flags) & ~status_flags) |-> $past(status_wr))
		else $error("status flag cleared without software write");
	AST_TRAP_INSTR: assert property (breakpoint_trap_instr |-> debug_exc)
		else $error("trap instruction gave no exception");
	AST_STEP: assert property (s_step_take |-> debug_exc ##1 s_step_logged)
		else $error("single step not raised or not logged");
	AST_EXEC_BEFORE: assert property (s_exec_armed0 |-> exec_break && debug_exc)
		else $error("execute breakpoint late");
	AST_LOCAL_CLEAR: assert property (task_switch |=> (debug_control_reg & `CTRL_LOCAL_MASK) == 32'h0)
		else $error("local enables survived task switch");
	AST_GLOBAL_KEEP: assert property (task_switch && !control_wr |=> $stable(debug_control_reg[7]))
		else $error("global enable changed on task switch");
	AST_LOCK_CLEAR: assert property (debug_exc |=> !debug_control_reg[`CTRL_LOCK_BIT])
		else $error("access lock kept after exception");
	AST_TASK_FLAG: assert property (s_task_trap |=> status_flags[5])
		else $error("task switch flag not set");
	AST_PRIV: assert property (reg_wr && !priv_ok && !task_switch && !debug_exc |=> $stable(debug_control_reg))
		else $error("unprivileged write took effect");
	AST_DATA_WRITE_ONLY: assert property (data_valid && !data_write &&
		debug_control_reg[21:20] == 2'h1 |-> !bif.data_hit[1])
		else $error("write-only breakpoint hit on a read");
	// Unused codes and refused moves are where a slip would hide
	AST_STATUS_HOLD: assert property (!take && !status_wr |=> $stable(status_flags))
		else $error("status changed with no cause and no write");
	AST_STEP_ONLY: assert property (!step_trip && !status_wr |=> $stable(status_flags[4]))
		else $error("single step flag set without single step");
	AST_TASK_ONLY: assert property (!task_trip && !status_wr |=> $stable(status_flags[5]))
		else $error("task switch flag set without task trap");
	AST_RAW_HIT: assert property (take && data_valid && bif.data_hit[1] |=> status_flags[1])
		else $error("hit flag 1 not captured");
	AST_NO_EXC_IDLE: assert property (s_quiet |-> !debug_exc)
		else $error("exception with no cause");
	AST_LOCK_REFUSE: assert property (s_locked_read |-> debug_exc ##1 (reg_rdata == 32'h0 && !lock))
		else $error("locked read not refused");
	AST_PRIV_READ: assert property (reg_rd && cur_priv != 2'h0 && !real_mode |=> reg_rdata == 32'h0)
		else $error("unprivileged read returned data");
	AST_PRIV_ADDR: assert property (reg_wr && !priv_ok |=> $stable(breakpoint_address_reg[0]))
		else $error("unprivileged address write took effect");
	AST_ADDR_WRITE: assert property (addr_wr && reg_sel == 3'h2 |=>
		breakpoint_address_reg[2] == $past(reg_wdata))
		else $error("address register 2 not written");
	AST_CTRL_FIXED: assert property ((debug_control_reg & ~(`CTRL_WR_MASK | `CTRL_RESET)) == 32'h0)
		else $error("reserved control bits changed");
	AST_GLOBAL_ALL: assert property (task_switch && !control_wr |=> $stable(global_bits))
		else $error("global enables changed on task switch");
	AST_UNUSED_KIND: assert property (data_valid && debug_control_reg[21:20] == 2'h2 |-> !bif.data_hit[1])
		else $error("unused access type matched");
	AST_UNUSED_LEN: assert property (debug_control_reg[23:22] == 2'h2 |-> !bif.data_hit[1])
		else $error("unused length matched");
endmodule

//--- sim/tb_debug_breakpoint_unit.sv
// Purpose: Self-checking bench for the breakpoint unit
// Assumes: Inputs change at the falling edge, reads checked from a queue
// Notes:   Address 0x1000 is kept fixed in slot 1 so the data table can aim at it
`timescale 1ns/100ps
module tb_debug_breakpoint_unit;
	import debug_break_pkg::*;
	logic        ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, real_mode = 0, rd_d = 0;
	logic        fetch_valid = 0, instr_done = 0, trap_instr = 0, data_valid = 0, data_write = 0;
	logic        task_switch = 0, task_trap_bit = 0, priv_fault, debug_exc, exec_break;
	logic [2:0]  reg_sel = 0;
	logic [1:0]  cur_priv = 0, data_size = 0;
	word_t       reg_wdata = 0, fetch_addr = 0, flags = 0, data_addr = 0, reg_rdata, rnd, t_a[4];
	word_t       exp_q[$];
	logic [11:0] tab[11] = '{12'h4A1, 12'h420, 12'hD29, 12'hD30, 12'hFB9, 12'hF9B,
	                         12'hBA6, 12'hEA6, 12'h020, 12'hC06, 12'hF24};
	int          fails = 0, n_compared = 0, cyc = 0;

	debug_breakpoint_unit i_dut (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_sel(reg_sel), .reg_wdata(reg_wdata), .cur_priv(cur_priv), .real_mode(real_mode),
		.reg_rdata(reg_rdata), .priv_fault(priv_fault), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
		.instr_done(instr_done), .processor_flags_reg(flags), .breakpoint_trap_instr(trap_instr),
		.data_valid(data_valid), .data_write(data_write), .data_addr(data_addr), .data_size(data_size),
		.task_switch(task_switch), .task_trap_bit(task_trap_bit), .debug_exc(debug_exc), .exec_break(exec_break));

	always #12.5 ref_clk = ~ref_clk;

	function automatic word_t lfsr(input word_t s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input word_t g, input word_t e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wrap_up;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One move instruction; reads leave their expected value in the queue
	task automatic req(input logic w, input logic [2:0] s, input word_t d, input word_t e, input logic ex,
			input logic f);
		@(negedge ref_clk);
		reg_wr = w;
		reg_rd = !w;
		reg_sel = s;
		reg_wdata = d;
		if (!w)
			exp_q.push_back(e);
		#1;
		chk(debug_exc, ex);
		chk(priv_fault, f);
		@(negedge ref_clk);
		reg_wr = 0;
		reg_rd = 0;
	endtask

	// Event inputs are set by the caller; checked once they settle, then dropped
	task automatic hit(input logic e, input logic b);
		#1;
		chk(debug_exc, e);
		chk(exec_break, b);
		@(negedge ref_clk);
		{fetch_valid, instr_done, trap_instr, data_valid, task_switch, task_trap_bit} = '0;
		flags = 0;
	endtask

	// Read data is registered, so it is due one cycle after the request
	always @(posedge ref_clk) rd_d <= reg_rd;
	always @(negedge ref_clk) begin
		if (rd_d && exp_q.size() > 0)
			chk(reg_rdata, exp_q.pop_front());
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			wrap_up;
		end
	end

	initial begin
		rnd = 32'd79341;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk) srst = 0;
		req(0, 3'h7, 0, 32'h0000_0400, 0, 0);
		req(0, 3'h6, 0, 32'h0000_0FF0, 0, 0);
		for (int i = 0; i < 4; i++) begin
			t_a[i] = (i == 1) ? 32'h0000_1000 : rnd;
			rnd = lfsr(rnd);
			req(1, i[2:0], t_a[i], 0, 0, 0);
			req(0, i[2:0], 0, t_a[i], 0, 0);
		end
		// Lock kept clear, or the read back would be refused
		req(1, 3'h7, rnd & 32'hFFFF_DFFF, 0, 0, 0);
		req(0, 3'h7, 0, (rnd & 32'hFFFF_03FF) | 32'h0000_0400, 0, 0);
		req(1, 3'h7, 32'h0000_0000, 0, 0, 0);
		// Selectors 4 and 5 hold nothing and must not alias an address register
		req(1, 3'h4, 32'hFFFF_FFFF, 0, 0, 0);
		req(0, 3'h5, 0, 32'h0000_0000, 0, 0);
		req(0, 3'h0, 0, t_a[0], 0, 0);
		// Unprivileged moves are refused; real mode counts as most privileged
		cur_priv = 2'h3;
		req(1, 3'h0, 32'h0000_0BAD, 0, 0, 1);
		req(0, 3'h0, 0, 32'h0000_0000, 0, 1);
		real_mode = 1;
		req(0, 3'h0, 0, t_a[0], 0, 0);
		cur_priv = 0;
		real_mode = 0;
		// Execute breakpoint on slot 0, one byte long
		req(1, 3'h7, 32'h0000_0001, 0, 0, 0);
		@(negedge ref_clk) {fetch_valid, fetch_addr} = {1'b1, t_a[0]};
		hit(1, 1);
		@(negedge ref_clk) {fetch_valid, fetch_addr} = {1'b1, t_a[0] + 32'h1};
		hit(0, 0);
		req(0, 3'h6, 0, 32'h0000_0FF1, 0, 0);
		// Data kinds, lengths and overlaps against slot 1
		for (int i = 0; i < 11; i++) begin
			req(1, 3'h6, 0, 0, 0, 0);
			req(1, 3'h7, {8'h00, tab[i][9:8], tab[i][11:10], 20'h00008}, 0, 0, 0);
			@(negedge ref_clk);
			{data_valid, data_write, data_size} = {1'b1, tab[i][7], tab[i][2:1]};
			data_addr = 32'h0000_0FFC + tab[i][6:3];
			hit(tab[i][0], 0);
			req(0, 3'h6, 0, {28'h0000_0FF, 2'b00, tab[i][0], 1'b0}, 0, 0);
		end
		// Single step with an unenabled raw hit in the same cycle
		req(1, 3'h6, 0, 0, 0, 0);
		req(1, 3'h7, 0, 0, 0, 0);
		@(negedge ref_clk) {fetch_valid, fetch_addr, instr_done, flags} = {1'b1, t_a[0], 1'b1, 32'h100};
		hit(1, 0);
		repeat (3) @(negedge ref_clk);
		req(0, 3'h6, 0, 32'h0000_4FF1, 0, 0);
		@(negedge ref_clk) trap_instr = 1;
		hit(1, 0);
		// Task switch into a trapping task drops the local enables
		req(1, 3'h6, 0, 0, 0, 0);
		req(1, 3'h7, 32'h0000_00FF, 0, 0, 0);
		@(negedge ref_clk) {task_switch, task_trap_bit} = 2'b11;
		hit(1, 0);
		req(0, 3'h7, 0, 32'h0000_04AA, 0, 0);
		req(0, 3'h6, 0, 32'h0000_8FF0, 0, 0);
		// Lock refuses the next access and is dropped by the exception it raises
		req(1, 3'h7, 32'h0000_2000, 0, 0, 0);
		req(0, 3'h7, 0, 32'h0000_0000, 1, 0);
		req(0, 3'h7, 0, 32'h0000_0400, 0, 0);
		repeat (2) @(negedge ref_clk);
		wrap_up;
	end
endmodule
